// ---- design/t16bac_counter.v ----
// 16-bit timer counter core with byte-wise CPU access via a shared high-byte latch
//
// Behaviour
// (RULE1) One shared 8-bit high-byte latch per timer
// (RULE2) Low-byte write loads latch and byte together
// (RULE3) Low-byte read copies upper byte to latch
// (RULE4) Compare reads bypass latch, leave it unchanged
// (RULE5) CPU writes high first, reads low first
// (RULE6) CPU masks interrupts around two-byte accesses
// (RULE7) Latch persists across several low-byte writes
// (RULE8) Counter upper-byte address accesses the latch
// (RULE9) Counter visible as two byte locations
// (RULE10) Clock-select zero stops the counter
// (RULE11) Counter accessible whether or not ticking
// (RULE12) CPU write beats clear or count
// (RULE13) Tick clears, increments or decrements by mode
// (RULE14) Four-bit mode field split over controls
// (RULE15) Bottom and top indications generated
// (RULE16) Overflow flag set per mode, interrupt source
// (RULE17) Bottom is 0x0000, maximum is 0xFFFF
// (RULE18) Top fixed, compare A or capture
// (RULE19) Power-reduction bit must be clear first
// (RULE20) Latch changes only on latching accesses
`timescale 1ns/1ps
`include "t16bac_defines.vh"

module t16bac_counter
(
   // Clock and reset
   input  wire        ref_clk,
   input  wire        arst_n,
   // CPU byte bus
   input  wire [3:0]  busAddr,
   input  wire        busWrite,
   input  wire        busRead,
   input  wire [7:0]  busWrData,
   output reg  [7:0]  busRdData,
   // Tick, power, capture event and overflow acknowledge
   input  wire        timerTick,
   input  wire        timerPowerReduction,
   input  wire        captureEvent,
   input  wire        overflowAck,
   // Status and values
   output reg  [15:0] timerCount,
   output reg  [15:0] compareValueA,
   output reg  [15:0] compareValueB,
   output reg  [15:0] captureValue,
   output reg         overflowFlag,
   output reg         topPulse,
   output reg         bottomPulse,
   output reg         countDown
);

   // ----------------------------------------------------------------
   // State and decode
   // ----------------------------------------------------------------
   reg  [7:0]  highLatch;      // Shared temporary high byte [RULE1]
   reg  [7:0]  controlA;
   reg  [7:0]  controlB;
   reg  [15:0] next_timerCount;
   reg  [15:0] topValue;
   reg         next_countDown;
   reg         ovfEvent;
   reg         topEvent;
   reg         bottomEvent;

   wire [3:0] waveformMode = {controlB[`T16_CTRLB_MODE_LSB+1:`T16_CTRLB_MODE_LSB],
                              controlA[`T16_CTRLA_MODE_LSB+1:`T16_CTRLA_MODE_LSB]}; // [RULE14]
   wire [2:0] clockSelect  = controlB[`T16_CTRLB_CLK_LSB+2:`T16_CTRLB_CLK_LSB];
   // Ticks pass only with a clock source and power on [RULE10] [RULE19]
   wire       tickEn       = timerTick && (clockSelect != 3'h0) && !timerPowerReduction;

   wire wrCntLo  = busWrite && (busAddr == `T16_ADDR_CNT_LO);
   wire wrCapLo  = busWrite && (busAddr == `T16_ADDR_CAP_LO);
   wire wrCmpALo = busWrite && (busAddr == `T16_ADDR_CMPA_LO);
   wire wrCmpBLo = busWrite && (busAddr == `T16_ADDR_CMPB_LO);
   wire wrAnyHi  = busWrite && ((busAddr == `T16_ADDR_CNT_HI) ||
                   (busAddr == `T16_ADDR_CAP_HI) || (busAddr == `T16_ADDR_CMPA_HI) ||
                   (busAddr == `T16_ADDR_CMPB_HI));
   wire rdCntLo  = busRead && (busAddr == `T16_ADDR_CNT_LO);
   wire rdCapLo  = busRead && (busAddr == `T16_ADDR_CAP_LO);

   // Modes with the capture value as top allow capture writes
   wire capTopMode = (waveformMode == 4'h8) || (waveformMode == 4'ha) ||
                     (waveformMode == 4'hc) || (waveformMode == 4'he);
   // Dual-slope (phase correct) modes
   wire dualSlope  = (waveformMode == 4'h1) || (waveformMode == 4'h2) ||
                     (waveformMode == 4'h3) || (waveformMode == 4'h8) ||
                     (waveformMode == 4'h9) || (waveformMode == 4'ha) ||
                     (waveformMode == 4'hb);
   // Non-PWM modes flag overflow at maximum
   wire maxOvfMode = (waveformMode == 4'h0) || (waveformMode == 4'h4) ||
                     (waveformMode == 4'hc);

   // ----------------------------------------------------------------
   // Top value selection
   // ----------------------------------------------------------------
   always @*
   begin
      case (waveformMode)
         4'h0:    topValue = `T16_MAX;           // [RULE17]
         4'h1:    topValue = `T16_TOP_8BIT;      // [RULE18]
         4'h2:    topValue = `T16_TOP_9BIT;
         4'h3:    topValue = `T16_TOP_10BIT;
         4'h4:    topValue = compareValueA;
         4'h5:    topValue = `T16_TOP_8BIT;
         4'h6:    topValue = `T16_TOP_9BIT;
         4'h7:    topValue = `T16_TOP_10BIT;
         4'h8:    topValue = captureValue;
         4'h9:    topValue = compareValueA;
         4'ha:    topValue = captureValue;
         4'hb:    topValue = compareValueA;
         4'hc:    topValue = captureValue;
         4'he:    topValue = captureValue;
         4'hf:    topValue = compareValueA;
         default: topValue = `T16_MAX;
      endcase
   end

   // ----------------------------------------------------------------
   // Count sequence
   // ----------------------------------------------------------------
   always @*
   begin
      next_timerCount = timerCount;
      next_countDown  = countDown;
      ovfEvent        = 1'b0;
      topEvent        = 1'b0;
      bottomEvent     = 1'b0;
      if (wrCntLo)
      begin
         // CPU write overrides any tick in this cycle [RULE12] [RULE2] [RULE11]
         next_timerCount = {highLatch, busWrData};
      end
      else if (tickEn)
      begin
         if (dualSlope)
         begin
            // Up to top, then down to bottom [RULE13]
            if (!countDown && (timerCount >= topValue))
            begin
               next_countDown  = 1'b1;
               next_timerCount = timerCount - 16'h0001;
               topEvent        = 1'b1;
            end
            else if (countDown && (timerCount == `T16_BOTTOM))
            begin
               next_countDown  = 1'b0;
               next_timerCount = timerCount + 16'h0001;
               bottomEvent     = 1'b1;
               ovfEvent        = 1'b1;               // [RULE16]
            end
            else if (countDown)
               next_timerCount = timerCount - 16'h0001;
            else
               next_timerCount = timerCount + 16'h0001;
         end
         else
         begin
            next_countDown = 1'b0;
            if (timerCount == topValue)
            begin
               next_timerCount = `T16_BOTTOM;      // Clear at top [RULE13]
               topEvent        = 1'b1;
               bottomEvent     = 1'b1;
               ovfEvent        = !maxOvfMode;      // [RULE16]
            end
            else
               next_timerCount = timerCount + 16'h0001;
            if (maxOvfMode && (timerCount == `T16_MAX))
               ovfEvent = 1'b1;                    // [RULE16] [RULE17]
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter, indications and overflow flag
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timerCount   <= `T16_WORD_RESET;
         countDown    <= 1'b0;
         topPulse     <= 1'b0;
         bottomPulse  <= 1'b0;
         overflowFlag <= 1'b0;
      end
      else
      begin
         timerCount  <= next_timerCount;
         countDown   <= next_countDown;
         topPulse    <= topEvent;                  // [RULE15]
         bottomPulse <= bottomEvent;               // [RULE15]
         // Set wins over acknowledge or write-one clear
         if (ovfEvent)
            overflowFlag <= 1'b1;                  // [RULE16]
         else if (overflowAck || (busWrite && (busAddr == `T16_ADDR_FLAGS) &&
                  busWrData[`T16_FLAG_OVF_BIT]))
            overflowFlag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Latch, control, compare and capture registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         highLatch     <= 8'h00;
         controlA      <= `T16_CTRL_RESET;
         controlB      <= `T16_CTRL_RESET;
         compareValueA <= `T16_WORD_RESET;
         compareValueB <= `T16_WORD_RESET;
         captureValue  <= `T16_WORD_RESET;
      end
      else
      begin
         // Latch updates only on latching accesses, else holds [RULE20] [RULE7]
         if (wrAnyHi)
            highLatch <= busWrData;                // [RULE8]
         else if (rdCntLo)
            highLatch <= timerCount[15:8];         // [RULE3]
         else if (rdCapLo)
            highLatch <= captureValue[15:8];       // [RULE3]
         if (busWrite && (busAddr == `T16_ADDR_CTRL_A))
            controlA <= busWrData;
         if (busWrite && (busAddr == `T16_ADDR_CTRL_B))
            controlB <= busWrData;
         if (wrCmpALo)
            compareValueA <= {highLatch, busWrData}; // [RULE2]
         if (wrCmpBLo)
            compareValueB <= {highLatch, busWrData}; // [RULE2]
         if (wrCapLo && capTopMode)
            captureValue <= {highLatch, busWrData};  // [RULE2]
         else if (captureEvent && !capTopMode)
            captureValue <= timerCount;
      end
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the read strobe
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         busRdData <= 8'h00;
      else if (busRead)
      begin
         case (busAddr)
            `T16_ADDR_CTRL_A:  busRdData <= controlA;
            `T16_ADDR_CTRL_B:  busRdData <= controlB;
            `T16_ADDR_CNT_LO:  busRdData <= timerCount[7:0];     // [RULE9]
            `T16_ADDR_CNT_HI:  busRdData <= highLatch;           // [RULE8]
            `T16_ADDR_CAP_LO:  busRdData <= captureValue[7:0];
            `T16_ADDR_CAP_HI:  busRdData <= highLatch;
            `T16_ADDR_CMPA_LO: busRdData <= compareValueA[7:0];
            `T16_ADDR_CMPA_HI: busRdData <= compareValueA[15:8]; // [RULE4]
            `T16_ADDR_CMPB_LO: busRdData <= compareValueB[7:0];
            `T16_ADDR_CMPB_HI: busRdData <= compareValueB[15:8]; // [RULE4]
            `T16_ADDR_FLAGS:   busRdData <= {7'h00, overflowFlag};
            default:           busRdData <= 8'h00;
         endcase
      end
   end

endmodule

// ---- include/t16bac_defines.vh ----
// Constants for the 16-bit timer byte-access and counter core
`ifndef T16BAC_DEFINES_VH
`define T16BAC_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses (4-bit I/O space)
// ----------------------------------------------------------------
`define T16_ADDR_CTRL_A     4'h0
`define T16_ADDR_CTRL_B     4'h1
`define T16_ADDR_CNT_LO     4'h4
`define T16_ADDR_CNT_HI     4'h5
`define T16_ADDR_CAP_LO     4'h6
`define T16_ADDR_CAP_HI     4'h7
`define T16_ADDR_CMPA_LO    4'h8
`define T16_ADDR_CMPA_HI    4'h9
`define T16_ADDR_CMPB_LO    4'ha
`define T16_ADDR_CMPB_HI    4'hb
`define T16_ADDR_FLAGS      4'hc

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define T16_CTRLA_MODE_LSB  0
`define T16_CTRLB_CLK_LSB   0
`define T16_CTRLB_MODE_LSB  3
`define T16_FLAG_OVF_BIT    0
`define T16_CTRL_RESET      8'h00
`define T16_WORD_RESET      16'h0000

// ----------------------------------------------------------------
// Counter limits
// ----------------------------------------------------------------
`define T16_BOTTOM          16'h0000
`define T16_MAX             16'hffff
`define T16_TOP_8BIT        16'h00ff
`define T16_TOP_9BIT        16'h01ff
`define T16_TOP_10BIT       16'h03ff

`endif

// ---- verif/t16bac_counter_chk.sv ----
// Port assertions for the timer byte-access counter
`timescale 1ns/1ps

module t16bac_counter_chk
(
   // Clock and reset
   input wire        ref_clk,
   input wire        arst_n,
   // CPU byte bus
   input wire [3:0]  busAddr,
   input wire        busWrite,
   input wire        busRead,
   input wire [7:0]  busWrData,
   input wire [7:0]  busRdData,
   // Tick and status
   input wire        timerTick,
   input wire        timerPowerReduction,
   input wire        overflowAck,
   input wire [15:0] timerCount,
   input wire [15:0] compareValueA,
   input wire        overflowFlag,
   input wire        topPulse,
   input wire        bottomPulse
);
   // ------------------------------
   // Mirrored control fields
   // ------------------------------
   reg  [3:0] mode;
   reg  [2:0] clkSel;
   wire       cntWr = busWrite && busAddr == 4'h4;
   wire       step = timerTick && clkSel != 3'h0 && !timerPowerReduction && !cntWr;
   wire       flagClr = overflowAck || (busWrite && busAddr == 4'hc && busWrData[0]);

   // Follow control writes
   always @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
      begin
         mode <= 4'h0;
         clkSel <= 3'h0;
      end
      else if (busWrite && busAddr == 4'h0)
         mode[1:0] <= busWrData[1:0];
      else if (busWrite && busAddr == 4'h1)
      begin
         mode[3:2] <= busWrData[4:3];
         clkSel <= busWrData[2:0];
      end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence lowRead;
      busRead && busAddr == 4'h4 ##1 busRead && busAddr == 4'h5;
   endsequence
   sequence hiThenLow;
      busWrite && busAddr[0] && busAddr > 4'h4 ##1 cntWr;
   endsequence

   a_low_write: assert property (cntWr |=> timerCount[7:0] == $past(busWrData))
      else $error("count low write lost");
   a_stop_hold: assert property (!step && !cntWr |=> $stable(timerCount))
      else $error("count moved without tick");
   a_up_step: assert property (step && mode == 4'h0 |=> timerCount == $past(timerCount) + 16'h1)
      else $error("count did not step");
   a_max_wrap: assert property (step && mode == 4'h0 && timerCount == 16'hffff |=>
      timerCount == 16'h0000 && overflowFlag && topPulse && bottomPulse)
      else $error("wrap at max wrong");
   a_cmp_top: assert property (step && mode == 4'h4 && timerCount == compareValueA |=>
      timerCount == 16'h0000 && topPulse)
      else $error("compare top wrong");
   a_fixed_top: assert property (step && mode == 4'h5 && timerCount == 16'h00ff |=>
      timerCount == 16'h0000 && overflowFlag)
      else $error("fixed top wrong");
   a_latch_read: assert property (lowRead |=> busRdData == ($past(timerCount, 2) >> 8))
      else $error("latched upper byte wrong");
   a_cmp_bypass: assert property (busRead && busAddr == 4'h9 |=> busRdData == ($past(compareValueA) >> 8))
      else $error("compare upper byte wrong");
   a_shared_latch: assert property (hiThenLow |=> timerCount[15:8] == $past(busWrData, 2))
      else $error("shared latch not used");
   a_flag_clear: assert property ($fell(overflowFlag) |-> $past(flagClr))
      else $error("flag fell without clear");
endmodule

bind t16bac_counter t16bac_counter_chk chk (.*);

// ---- verif/t16bac_cpu_model.sv ----
// CPU byte-bus model driving the timer register port
`timescale 1ns/1ps

module t16bac_cpu_model
(
   // Clock
   input  wire       ref_clk,
   // Byte bus
   output reg  [3:0] busAddr,
   output reg        busWrite,
   output reg        busRead,
   output reg  [7:0] busWrData,
   input  wire [7:0] busRdData
);
   // ------------------------------
   // Bus cycles, one access per edge
   // ------------------------------
   initial
   begin
      busAddr = 4'h0;
      busWrite = 1'b0;
      busRead = 1'b0;
      busWrData = 8'h00;
   end

   // Write strobe stays up until the next call
   task wr(input [3:0] a, input [7:0] d);
   begin
      @(posedge ref_clk);
      #1;
      busRead = 1'b0;
      busWrite = 1'b1;
      busAddr = a;
      busWrData = d;
   end
   endtask

   // Read; q is the answer to the access taken at this edge
   task rd(input [3:0] a, output [7:0] q);
   begin
      @(posedge ref_clk);
      #1;
      q = busRdData;
      busWrite = 1'b0;
      busRead = 1'b1;
      busAddr = a;
      busWrData = ~busWrData;
   end
   endtask

   // Release the bus; data toggles so stale bytes never match
   task idle(output [7:0] q);
   begin
      @(posedge ref_clk);
      #1;
      q = busRdData;
      busWrite = 1'b0;
      busRead = 1'b0;
      busWrData = ~busWrData;
   end
   endtask

   // Word write, upper byte first, nothing in between
   task wr16(input [3:0] a, input [15:0] v);
      reg [7:0] x;
   begin
      wr(a + 4'h1, v[15:8]);
      wr(a, v[7:0]);
      idle(x);
   end
   endtask

   // Word read, lower byte first, nothing in between
   task rd16(input [3:0] a, output [15:0] v);
      reg [7:0] x;
   begin
      rd(a, x);
      rd(a + 4'h1, v[7:0]);
      idle(v[15:8]);
   end
   endtask
endmodule

// ---- verif/timer16_byte_access_counter_test.sv ----
// Self-checking bench for the timer byte-access counter
`timescale 1ns/1ps

module timer16_byte_access_counter_test;
   // ------------------------------
   // Signals, clock, instances
   // ------------------------------
   reg         ref_clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         timerTick = 1'b0;
   reg         timerPowerReduction = 1'b0; // Timer enabled before use
   reg         captureEvent = 1'b0;
   reg         overflowAck = 1'b0;
   wire [3:0]  busAddr;
   wire        busWrite;
   wire        busRead;
   wire [7:0]  busWrData;
   wire [7:0]  busRdData;
   wire [15:0] timerCount;
   wire [15:0] compareValueA;
   wire [15:0] compareValueB;
   wire        overflowFlag;
   wire        topPulse;
   wire        bottomPulse;
   wire        countDown;
   wire [15:0] captureValue;
   integer     error_cnt = 0;
   integer     cmp_count = 0;
   reg  [15:0] v;
   reg  [7:0]  b;

   // Free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   t16bac_cpu_model cpu (.ref_clk(ref_clk), .busAddr(busAddr), .busWrite(busWrite),
      .busRead(busRead), .busWrData(busWrData), .busRdData(busRdData));
   t16bac_counter dut (.ref_clk(ref_clk), .arst_n(arst_n), .busAddr(busAddr),
      .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData), .busRdData(busRdData),
      .timerTick(timerTick), .timerPowerReduction(timerPowerReduction),
      .captureEvent(captureEvent), .overflowAck(overflowAck), .timerCount(timerCount),
      .compareValueA(compareValueA), .compareValueB(compareValueB),
      .captureValue(captureValue), .overflowFlag(overflowFlag), .topPulse(topPulse),
      .bottomPulse(bottomPulse), .countDown(countDown));

   // ------------------------------
   // Helpers
   // ------------------------------
   task chk(input string n, input [15:0] e, input [15:0] g);
   begin
      cmp_count = cmp_count + 1;
      if (e !== g)
      begin
         error_cnt = error_cnt + 1;
         $display("BAD %0s expected %h seen %h", n, e, g);
      end
   end
   endtask

   task final_report;
   begin
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   // Ticks on n consecutive edges
   task tick(input integer n);
   begin
      repeat (n)
      begin
         @(posedge ref_clk);
         #1;
         timerTick = 1'b1;
      end
      @(posedge ref_clk);
      #1;
      timerTick = 1'b0;
   end
   endtask

   // Control A then B
   task ctrl(input [7:0] a, input [7:0] c);
   begin
      cpu.wr(4'h0, a);
      cpu.wr(4'h1, c);
      cpu.idle(b);
   end
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task t_access;
   begin
      cpu.rd16(4'hd, v);
      chk("unmapped", 16'h0000, v);
      cpu.wr16(4'h4, 16'h01ff);
      tick(3);
      cpu.rd16(4'h4, v);
      chk("countRead", 16'h01ff, v);
      cpu.wr(4'h9, 8'ha5);
      cpu.wr(4'h4, 8'h11);
      cpu.wr(4'h8, 8'h22);
      cpu.wr(4'ha, 8'h33);
      cpu.idle(b);
      chk("countShared", 16'ha511, timerCount);
      chk("cmpAShared", 16'ha522, compareValueA);
      chk("cmpBShared", 16'ha533, compareValueB);
      cpu.wr16(4'h8, 16'h5a22);
      cpu.rd(4'h4, b);
      cpu.rd(4'h9, b);
      cpu.rd(4'h5, b);
      chk("cmpAUpper", 16'h005a, {8'h00, b});
      cpu.idle(b);
      chk("latchKept", 16'h00a5, {8'h00, b});
   end
   endtask

   task t_count;
   begin
      ctrl(8'h00, 8'h01);
      cpu.wr16(4'h4, 16'hfffe);
      tick(2);
      chk("wrap", 16'h0000, timerCount);
      chk("ovf", 16'h0001, {15'h0, overflowFlag});
      timerPowerReduction = 1'b1;
      tick(2);
      chk("powerOff", 16'h0000, timerCount);
      timerPowerReduction = 1'b0;
      overflowAck = 1'b1;
      cpu.idle(b);
      overflowAck = 1'b0;
      chk("ovfAck", 16'h0000, {15'h0, overflowFlag});
      timerTick = 1'b1;
      cpu.wr16(4'h4, 16'h1234);
      chk("writeWins", 16'h1234, timerCount);
      timerTick = 1'b0;
   end
   endtask

   task t_tops;
   begin
      ctrl(8'h00, 8'h09);
      cpu.wr16(4'h8, 16'h0003);
      cpu.wr16(4'h4, 16'h0000);
      tick(4);
      chk("cmpTop", 16'h0000, timerCount);
      chk("topPulse", 16'h0001, {15'h0, topPulse});
      ctrl(8'h01, 8'h09);
      cpu.wr16(4'h4, 16'h00fe);
      tick(2);
      chk("fixedTop", 16'h0000, timerCount);
      chk("topOvf", 16'h0001, {15'h0, overflowFlag});
   end
   endtask

   // Phase correct 8-bit: turn at top, overflow at bottom
   task t_slope;
   begin
      ctrl(8'h01, 8'h01);
      cpu.wr16(4'h4, 16'h00fe);
      tick(2);
      chk("slopeTop", 16'h00fe, timerCount);
      chk("slopeDown", 16'h0001, {15'h0, countDown});
      chk("slopeTopPulse", 16'h0001, {15'h0, topPulse});
      cpu.wr(4'hc, 8'h01);
      cpu.wr16(4'h4, 16'h0001);
      chk("ovfClear", 16'h0000, {15'h0, overflowFlag});
      tick(2);
      chk("slopeBottom", 16'h0001, timerCount);
      chk("slopeUp", 16'h0000, {15'h0, countDown});
      chk("bottomPulse", 16'h0001, {15'h0, bottomPulse});
      chk("slopeOvf", 16'h0001, {15'h0, overflowFlag});
   end
   endtask

   // Capture read through the latch, capture as top
   task t_capture;
   begin
      cpu.wr16(4'h4, 16'h3c01);
      captureEvent = 1'b1;
      cpu.idle(b);
      captureEvent = 1'b0;
      cpu.wr16(4'h4, 16'h0001);
      cpu.rd16(4'h6, v);
      chk("capRead", 16'h3c01, v);
      chk("capValue", 16'h3c01, captureValue);
      ctrl(8'h00, 8'h19);
      cpu.rd16(4'h0, v);
      chk("ctrlRead", 16'h1900, v);
      cpu.wr16(4'h6, 16'h0005);
      chk("capWrite", 16'h0005, captureValue);
      cpu.wr16(4'h4, 16'h0003);
      tick(3);
      chk("capTop", 16'h0000, timerCount);
   end
   endtask

   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      t_access;
      t_count;
      t_tops;
      t_slope;
      t_capture;
      final_report;
   end

   initial
   begin
      #100000;
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule
